// ### usu_core.sv
// universal serial shift unit: shift register, 4-bit counter,
// three-wire and two-wire pin control, async start detector
// assumes the serial clock pin runs well below clk_i / 8 so
// every pin edge is seen by the system clock side
module usu_core
   import usu_pkg::*;
(
   // system
   input wire logic clk_i,
   input wire logic resetn_i,
   // configuration levels
   input wire logic [1:0] wire_mode_i,
   input wire logic external_clock_select_i,
   input wire logic edge_polarity_select_i,
   input wire logic wrap_irq_en_i,
   input wire logic start_irq_en_i,
   input wire logic clock_drive_en_i,
   input wire logic data_drive_en_i,
   input wire logic port_data_i,
   // software strobes and writes, timer match
   input wire logic ctrl_wr_i,
   input wire logic software_clock_strobe_i,
   input wire logic clock_toggle_strobe_i,
   input wire logic port_clock_wr_i,
   input wire logic port_clock_i,
   input wire logic data_wr_i,
   input wire logic [DATA_W-1:0] data_wdata_i,
   input wire logic cnt_wr_i,
   input wire logic [CNT_W-1:0] cnt_wdata_i,
   input wire logic wrap_clr_i,
   input wire logic start_clr_i,
   input wire logic timer_match_i,
   // status
   output logic [DATA_W-1:0] shift_data_o,
   output logic [CNT_W-1:0] count_o,
   output logic count_wrap_flag_o,
   output logic start_seen_flag_o,
   output logic wrap_irq_o,
   output logic start_irq_o,
   // serial pins
   input wire logic serial_clock_pin_i,
   input wire logic serial_data_in_i,
   output logic clock_pin_o,
   output logic clock_pin_oe_o,
   output logic data_out_o,
   output logic data_out_oe_o,
   output logic sda_o,
   output logic sda_oe_o
);

   function automatic logic tgl_edge(input logic [2:0] s);
      return s[2] ^ s[1];
   endfunction

   //----------------------------------------------------------
   // pin clock domain: capture data on both edges
   //----------------------------------------------------------
   logic pos_tgl, pos_bit, next_pos_tgl, next_pos_bit;
   logic neg_tgl, neg_bit, next_neg_tgl, next_neg_bit;

   always_comb
   begin
      next_pos_tgl = ~pos_tgl;
      next_pos_bit = serial_data_in_i;
      next_neg_tgl = ~neg_tgl;
      next_neg_bit = serial_data_in_i;
   end

   always_ff @(posedge serial_clock_pin_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         pos_tgl <= 1'b0;
         pos_bit <= 1'b0;
      end
      else
      begin
         pos_tgl <= next_pos_tgl;
         pos_bit <= next_pos_bit;
      end
   end

   always_ff @(negedge serial_clock_pin_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         neg_tgl <= 1'b0;
         neg_bit <= 1'b0;
      end
      else
      begin
         neg_tgl <= next_neg_tgl;
         neg_bit <= next_neg_bit;
      end
   end

   //----------------------------------------------------------
   // start detector, clocked by the data line itself
   //----------------------------------------------------------
   // no system clock needed, so a start is caught while asleep
   logic two_wire;
   logic start_tgl, next_start_tgl;

   assign two_wire = wire_mode_i[1];

   always_comb
   begin
      next_start_tgl = start_tgl;
      if (two_wire && serial_clock_pin_i) // R21
         next_start_tgl = ~start_tgl; // R15
   end

   always_ff @(negedge serial_data_in_i or negedge resetn_i) // R22
   begin
      if (!resetn_i)
         start_tgl <= 1'b0;
      else
         start_tgl <= next_start_tgl;
   end

   //----------------------------------------------------------
   // synchronisers into clk_i
   //----------------------------------------------------------
   logic [2:0] pos_s, neg_s, start_s, lvl_s, di_s;
   logic [2:0] next_pos_s, next_neg_s, next_start_s;
   logic [2:0] next_lvl_s, next_di_s;

   always_comb
   begin
      next_pos_s = {pos_s[1:0], pos_tgl};
      next_neg_s = {neg_s[1:0], neg_tgl};
      next_start_s = {start_s[1:0], start_tgl};
      next_lvl_s = {lvl_s[1:0], serial_clock_pin_i};
      next_di_s = {di_s[1:0], serial_data_in_i};
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         pos_s <= SYNC_RST;
         neg_s <= SYNC_RST;
         start_s <= SYNC_RST;
         lvl_s <= SYNC_RST;
         di_s <= SYNC_RST;
      end
      else
      begin
         pos_s <= next_pos_s;
         neg_s <= next_neg_s;
         start_s <= next_start_s;
         lvl_s <= next_lvl_s;
         di_s <= next_di_s;
      end
   end

   //----------------------------------------------------------
   // shift register, counter, flags and pin drive
   //----------------------------------------------------------
   logic [DATA_W-1:0] sr, next_sr;
   logic [CNT_W-1:0] cnt, next_cnt;
   logic wrap_flag, next_wrap_flag, start_flag, next_start_flag;
   logic sw_count, next_sw_count, clk_out, next_clk_out;
   logic start_hold, next_start_hold, sample_bit, next_sample_bit;
   logic next_data_out, next_data_out_oe, next_sda_oe;
   logic next_clock_pin, next_clock_pin_oe;
   logic next_wrap_irq, next_start_irq, next_sda;
   logic pos_ev, neg_ev, start_ev, ext_edge, samp_ev, shift_ev;
   logic samp_val, toggle, sw_tick, int_tick, do_samp, do_shift;
   logic samp_in, shift_in, wrap_ev, wrap_hold, hold;
   logic [1:0] inc;
   logic [CNT_W:0] sum;

   always_comb
   begin
      pos_ev = tgl_edge(pos_s);
      neg_ev = tgl_edge(neg_s);
      start_ev = tgl_edge(start_s);
      // pin edges are ignored while toggle writes do the counting
      ext_edge = external_clock_select_i & ~sw_count; // R4
      samp_ev = ext_edge & (edge_polarity_select_i ? neg_ev : pos_ev); // R9
      shift_ev = ext_edge & (edge_polarity_select_i ? pos_ev : neg_ev);
      samp_val = edge_polarity_select_i ? neg_bit : pos_bit; // R18
      toggle = ctrl_wr_i & clock_toggle_strobe_i;
      sw_tick = external_clock_select_i & software_clock_strobe_i
                & toggle; // R25
      int_tick = ~external_clock_select_i &
                 (edge_polarity_select_i ? timer_match_i :
                  (ctrl_wr_i & software_clock_strobe_i)); // R13
      // current clock level decides whether a toggle samples or shifts
      do_samp = samp_ev | (sw_tick & (clk_out == edge_polarity_select_i));
      do_shift = shift_ev | int_tick |
                 (sw_tick & (clk_out != edge_polarity_select_i));
      samp_in = samp_ev ? samp_val : di_s[1];
      shift_in = int_tick ? di_s[1] : (do_samp ? samp_in : sample_bit);
      next_sample_bit = do_samp ? samp_in : sample_bit;

      next_sr = sr;
      if (data_wr_i)
         next_sr = data_wdata_i; // R26
      else if (do_shift)
         next_sr = {sr[DATA_W-2:0], shift_in}; // R2 R7

      inc = {1'b0, do_samp} + {1'b0, do_shift}; // R3
      sum = {1'b0, cnt} + {3'h0, inc};
      wrap_ev = ~cnt_wr_i & sum[CNT_W]; // R23
      next_cnt = cnt_wr_i ? cnt_wdata_i : sum[CNT_W-1:0]; // R26 R20

      // a set in the same cycle as a clear wins
      next_wrap_flag = wrap_ev | (wrap_flag & ~wrap_clr_i); // R11
      next_start_flag = (start_ev & two_wire) |
                        (start_flag & ~start_clr_i); // R15

      next_sw_count = sw_count;
      if (ctrl_wr_i)
         next_sw_count = external_clock_select_i & software_clock_strobe_i;

      next_clk_out = clk_out;
      if (port_clock_wr_i)
         next_clk_out = port_clock_i;
      else if (toggle)
         next_clk_out = ~clk_out; // R8

      // hold starts once the master has pulled the clock low
      next_start_hold = two_wire & next_start_flag &
                        (start_hold | ~lvl_s[1]); // R17
      wrap_hold = (wire_mode_i == WIRE_TWO_HOLD) & next_wrap_flag; // R19
      hold = next_start_hold | wrap_hold; // R5

      next_sda = 1'b0;
      next_data_out = next_sr[DATA_W-1];
      next_data_out_oe = 1'b0;
      next_sda_oe = 1'b0;
      next_clock_pin = next_clk_out;
      next_clock_pin_oe = 1'b0;
      unique case (wire_mode_i)
         WIRE_THREE:
         begin
            next_data_out_oe = data_drive_en_i; // R6
            next_clock_pin_oe = clock_drive_en_i;
         end
         WIRE_TWO, WIRE_TWO_HOLD:
         begin
            // open drain: released only when both bits are one
            next_sda_oe = ~(next_sr[DATA_W-1] & port_data_i); // R16
            next_clock_pin = 1'b0;
            next_clock_pin_oe = hold |
                                (clock_drive_en_i & ~next_clk_out); // R24
         end
         WIRE_OFF:
         begin
            next_clock_pin = next_clk_out;
         end
      endcase

      next_wrap_irq = next_wrap_flag & wrap_irq_en_i; // R1 R12
      next_start_irq = next_start_flag & start_irq_en_i; // R5
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         sr <= DATA_RST;
         cnt <= CNT_RST;
         wrap_flag <= 1'b0;
         start_flag <= 1'b0;
         sw_count <= 1'b0;
         clk_out <= 1'b0;
         start_hold <= 1'b0;
         sample_bit <= 1'b0;
         data_out_o <= 1'b0;
         data_out_oe_o <= 1'b0;
         sda_o <= 1'b0;
         sda_oe_o <= 1'b0;
         clock_pin_o <= 1'b0;
         clock_pin_oe_o <= 1'b0;
         wrap_irq_o <= 1'b0;
         start_irq_o <= 1'b0;
      end
      else
      begin
         sr <= next_sr;
         cnt <= next_cnt;
         wrap_flag <= next_wrap_flag;
         start_flag <= next_start_flag;
         sw_count <= next_sw_count;
         clk_out <= next_clk_out;
         start_hold <= next_start_hold;
         sample_bit <= next_sample_bit;
         data_out_o <= next_data_out;
         data_out_oe_o <= next_data_out_oe;
         sda_o <= next_sda;
         sda_oe_o <= next_sda_oe;
         clock_pin_o <= next_clock_pin;
         clock_pin_oe_o <= next_clock_pin_oe;
         wrap_irq_o <= next_wrap_irq;
         start_irq_o <= next_start_irq;
      end
   end

   assign shift_data_o = sr;
   assign count_o = cnt;
   assign count_wrap_flag_o = wrap_flag;
   assign start_seen_flag_o = start_flag;

   //----------------------------------------------------------
   // checks
   //----------------------------------------------------------
   chk_cnt_write_wins: assert property ( // R26
      @(posedge clk_i) disable iff (!resetn_i)
      cnt_wr_i |=> count_o == $past(cnt_wdata_i))
      else $error("counter write lost to increment");

   chk_wrap_on_max: assert property ( // R23
      @(posedge clk_i) disable iff (!resetn_i)
      (cnt == CNT_MAX && (do_samp || do_shift) && !cnt_wr_i)
      |=> count_wrap_flag_o && count_o != CNT_MAX)
      else $error("no wrap flag after counter maximum");

   chk_set_beats_clear: assert property ( // R11
      @(posedge clk_i) disable iff (!resetn_i)
      wrap_ev && wrap_clr_i |=> count_wrap_flag_o)
      else $error("wrap event lost against clear");

   chk_two_edge_count: assert property ( // R3
      @(posedge clk_i) disable iff (!resetn_i)
      (do_samp && do_shift && !cnt_wr_i && cnt < CNT_ACK_PRELOAD)
      |=> count_o == $past(cnt) + CNT_TWO)
      else $error("both edges not counted");

   chk_start_hold_low: assert property ( // R17
      @(posedge clk_i) disable iff (!resetn_i)
      next_start_hold |=> clock_pin_oe_o && !clock_pin_o)
      else $error("clock not held low after start");

   chk_sda_pull_low: assert property ( // R16
      @(posedge clk_i) disable iff (!resetn_i)
      two_wire && !(next_sr[DATA_W-1] && port_data_i) |=> sda_oe_o)
      else $error("data line not pulled low");

   chk_toggle_strobe: assert property ( // R8
      @(posedge clk_i) disable iff (!resetn_i)
      toggle && !port_clock_wr_i |=> clk_out != $past(clk_out))
      else $error("toggle strobe did not flip clock");

   chk_detect_mode: assert property ( // R21
      @(posedge clk_i) disable iff (!resetn_i)
      $rose(start_seen_flag_o) |-> $past(two_wire))
      else $error("start flag set outside two-wire mode");

   chk_sw_shift: assert property ( // R13
      @(posedge clk_i) disable iff (!resetn_i)
      int_tick && !data_wr_i |=>
      shift_data_o == {$past(sr[DATA_W-2:0]), $past(di_s[1])})
      else $error("software strobe did not shift");

   chk_wrap_irq: assert property ( // R1
      @(posedge clk_i) disable iff (!resetn_i)
      ##1 wrap_irq_o == (count_wrap_flag_o && $past(wrap_irq_en_i)))
      else $error("wrap request does not follow flag");

   chk_wrap_hold: assert property ( // R19
      @(posedge clk_i) disable iff (!resetn_i)
      wire_mode_i == WIRE_TWO_HOLD && next_wrap_flag
      |=> clock_pin_oe_o && !clock_pin_o)
      else $error("clock not held after wrap");

endmodule // usu_core

// ### usu_core_tb.sv
// self-checking bench for the universal serial shift unit
// assumes usu_pkg, usu_core and usu_spi_master are compiled first
module usu_core_tb;
   import usu_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   //----------------------------------------------------------------
   // signals
   //----------------------------------------------------------------
   logic clk_i = 1'b0, resetn_i, link_clk, sel, tw_scl, tw_sda, go;
   logic [1:0] wire_mode_i;
   logic external_clock_select_i, edge_polarity_select_i, wrap_irq_en_i;
   logic start_irq_en_i, clock_drive_en_i, data_drive_en_i, port_data_i;
   logic ctrl_wr_i, software_clock_strobe_i, clock_toggle_strobe_i;
   logic port_clock_wr_i, port_clock_i, data_wr_i, cnt_wr_i, wrap_clr_i;
   logic start_clr_i, timer_match_i, serial_clock_pin_i, serial_data_in_i;
   logic [7:0] data_wdata_i, shift_data_o, tx, rx;
   logic [3:0] cnt_wdata_i, count_o;
   logic count_wrap_flag_o, start_seen_flag_o, wrap_irq_o, start_irq_o;
   logic clock_pin_o, clock_pin_oe_o, data_out_o, data_out_oe_o;
   logic sda_o, sda_oe_o, p_sclk, p_mosi, busy;
   int err_count = 0, comparisons = 0, n;
   //----------------------------------------------------------------
   // clocks, wires and instances
   //----------------------------------------------------------------
   always #4 clk_i = ~clk_i;
   initial
   begin
      link_clk = 1'b0;
      #1.7;
      forever #3 link_clk = ~link_clk;
   end
   // pull-up on both two-wire lines; the unit only ever pulls low
   assign serial_clock_pin_i = clock_pin_oe_o ? clock_pin_o :
                               (sel ? tw_scl : p_sclk);
   assign serial_data_in_i = sel ? (sda_oe_o ? 1'b0 : tw_sda) : p_mosi;
   usu_core i_usu_core (.clk_i(clk_i), .resetn_i(resetn_i),
      .wire_mode_i(wire_mode_i), .timer_match_i(timer_match_i),
      .external_clock_select_i(external_clock_select_i),
      .edge_polarity_select_i(edge_polarity_select_i),
      .wrap_irq_en_i(wrap_irq_en_i), .start_irq_en_i(start_irq_en_i),
      .clock_drive_en_i(clock_drive_en_i), .port_data_i(port_data_i),
      .data_drive_en_i(data_drive_en_i), .ctrl_wr_i(ctrl_wr_i),
      .software_clock_strobe_i(software_clock_strobe_i),
      .clock_toggle_strobe_i(clock_toggle_strobe_i),
      .port_clock_wr_i(port_clock_wr_i), .port_clock_i(port_clock_i),
      .data_wr_i(data_wr_i), .data_wdata_i(data_wdata_i),
      .cnt_wr_i(cnt_wr_i), .cnt_wdata_i(cnt_wdata_i),
      .wrap_clr_i(wrap_clr_i), .start_clr_i(start_clr_i),
      .shift_data_o(shift_data_o), .count_o(count_o),
      .count_wrap_flag_o(count_wrap_flag_o), .wrap_irq_o(wrap_irq_o),
      .start_seen_flag_o(start_seen_flag_o), .start_irq_o(start_irq_o),
      .serial_clock_pin_i(serial_clock_pin_i), .sda_o(sda_o),
      .serial_data_in_i(serial_data_in_i), .clock_pin_o(clock_pin_o),
      .clock_pin_oe_o(clock_pin_oe_o), .data_out_o(data_out_o),
      .data_out_oe_o(data_out_oe_o), .sda_oe_o(sda_oe_o));
   usu_spi_master i_usu_spi_master (.link_clk_i(link_clk), .go_i(go),
      .tx_i(tx), .miso_i(data_out_oe_o ? data_out_o : ~data_out_o),
      .sclk_o(p_sclk), .mosi_o(p_mosi), .rx_o(rx), .busy_o(busy));
   //----------------------------------------------------------------
   // access tasks
   //----------------------------------------------------------------
   task automatic tick(input int k);
      repeat (k) @(posedge clk_i);
      #1;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic ctrl(input logic sw, input logic tg);
      ctrl_wr_i = 1'b1;
      software_clock_strobe_i = sw;
      clock_toggle_strobe_i = tg;
      tick(1);
      {ctrl_wr_i, software_clock_strobe_i, clock_toggle_strobe_i} = 3'h0;
      tick(1);
   endtask
   task automatic wr_data(input logic [7:0] d);
      data_wr_i = 1'b1;
      data_wdata_i = d;
      tick(1);
      data_wr_i = 1'b0;
      tick(1);
   endtask
   task automatic wr_cnt(input logic [3:0] c);
      cnt_wr_i = 1'b1;
      cnt_wdata_i = c;
      tick(1);
      cnt_wr_i = 1'b0;
      tick(1);
   endtask
   task automatic clr_wrap();
      wrap_clr_i = 1'b1;
      tick(1);
      wrap_clr_i = 1'b0;
      tick(1);
   endtask
   task automatic conclude();
      if (err_count == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   //----------------------------------------------------------------
   // watchdog and tests
   //----------------------------------------------------------------
   initial
   begin
      #100000;
      err_count++;
      conclude();
   end
   initial
   begin
      {resetn_i, go, wire_mode_i, external_clock_select_i} = 5'h0;
      {edge_polarity_select_i, start_irq_en_i, clock_drive_en_i} = 3'h0;
      {data_drive_en_i, port_data_i, ctrl_wr_i, port_clock_wr_i} = 4'h0;
      {software_clock_strobe_i, clock_toggle_strobe_i, port_clock_i} = 3'h0;
      {data_wr_i, cnt_wr_i, wrap_clr_i, start_clr_i, timer_match_i} = 5'h0;
      {data_wdata_i, cnt_wdata_i, tx} = 20'h00000;
      {sel, tw_scl, tw_sda, wrap_irq_en_i} = 4'h5;
      tick(6);
      resetn_i = 1'b1;
      tick(1);
      check(shift_data_o, DATA_RST);
      check({count_wrap_flag_o, start_seen_flag_o, count_o}, 8'h00);
      wire_mode_i = WIRE_THREE;
      wr_data(8'h81);
      ctrl(1'b1, 1'b0);
      check(shift_data_o, 8'h02);
      check(count_o, 8'h01);
      {cnt_wr_i, cnt_wdata_i, ctrl_wr_i, software_clock_strobe_i} = 7'h7b;
      tick(1);
      {cnt_wr_i, ctrl_wr_i, software_clock_strobe_i} = 3'h0;
      tick(1);
      check(count_o, CNT_ACK_PRELOAD);
      ctrl(1'b1, 1'b0);
      ctrl(1'b1, 1'b0);
      check({count_wrap_flag_o, count_o}, 8'h10);
      check(wrap_irq_o, 8'h01);
      clr_wrap();
      check(count_wrap_flag_o, 8'h00);
      edge_polarity_select_i = 1'b1;
      timer_match_i = 1'b1;
      tick(1);
      timer_match_i = 1'b0;
      tick(1);
      check(count_o, 8'h01);
      {edge_polarity_select_i, clock_drive_en_i} = 2'h1;
      {port_clock_wr_i, port_clock_i} = 2'h3;
      tick(1);
      port_clock_wr_i = 1'b0;
      tick(1);
      check({clock_pin_oe_o, clock_pin_o}, 8'h03);
      ctrl(1'b0, 1'b1);
      check({clock_pin_oe_o, clock_pin_o}, 8'h02);
      // let the synchronised pin edge of the toggle pass unclocked
      tick(4);
      external_clock_select_i = 1'b1;
      wr_cnt(CNT_RST);
      ctrl(1'b1, 1'b1);
      ctrl(1'b1, 1'b1);
      check(count_o, CNT_TWO);
      ctrl(1'b0, 1'b0);
      {clock_drive_en_i, data_drive_en_i, sel} = 3'h2;
      clr_wrap();
      wr_cnt(CNT_RST);
      wr_data(8'h3c);
      tx = 8'hc5;
      go = 1'b1;
      tick(1);
      go = 1'b0;
      for (n = 0; n < 400 && busy; n++)
         tick(1);
      tick(10);
      check(shift_data_o, 8'hc5);
      check(rx, 8'h3c);
      check({count_wrap_flag_o, count_o}, 8'h10);
      check(wrap_irq_o, 8'h01);
      {sel, tw_scl, tw_sda} = 3'h7;
      tick(5);
      tw_sda = 1'b0;
      tick(10);
      check(start_seen_flag_o, 8'h00);
      tw_sda = 1'b1;
      wr_data(8'hff);
      {port_data_i, start_irq_en_i, wire_mode_i} = {2'h3, WIRE_TWO};
      tick(5);
      check({sda_o, sda_oe_o}, 8'h00);
      tw_sda = 1'b0;
      tick(10);
      check({start_irq_o, start_seen_flag_o}, 8'h03);
      {tw_scl, tw_sda} = 2'h1;
      tick(10);
      check({clock_pin_oe_o, clock_pin_o}, 8'h02);
      start_clr_i = 1'b1;
      tick(1);
      start_clr_i = 1'b0;
      tick(5);
      check({clock_pin_oe_o, start_seen_flag_o}, 8'h00);
      port_data_i = 1'b0;
      tick(3);
      check(sda_oe_o, 8'h01);
      port_data_i = 1'b1;
      wr_data(8'h7f);
      check(sda_oe_o, 8'h01);
      wr_data(8'hff);
      wire_mode_i = WIRE_TWO_HOLD;
      clr_wrap();
      wr_cnt(CNT_ACK_PRELOAD);
      tw_sda = 1'b0;
      tick(5);
      tw_scl = 1'b1;
      tick(10);
      tw_scl = 1'b0;
      tick(10);
      check(shift_data_o, 8'hfe);
      check({count_wrap_flag_o, count_o}, 8'h10);
      check({clock_pin_oe_o, clock_pin_o}, 8'h02);
      // master releases the clock and must see it still stretched
      tw_scl = 1'b1;
      tick(2);
      check(serial_clock_pin_i, 8'h00);
      conclude();
   end
endmodule // usu_core_tb

// ### usu_pkg.sv
// constants shared by the universal serial shift unit
// assumes one system clock domain plus the serial clock pin and serial data line domains
//----------------------------------------------------------------
// How it works
// R1 - counter readable, writable; wrap raises interrupt request
// R2 - shift register and counter share one clock
// R3 - external clock counts both edges
// R4 - three sources: pin, timer match, software strobe
// R5 - two-wire: start interrupt, clock held low
// R6 - three-wire acts as SPI modes 0/1
// R7 - two units swap bytes after eight clocks
// R8 - toggle strobe flips master clock output
// R9 - polarity picks sampling edge, shift on other
// R10 - both ends set up data before first sample
// R11 - sixteen edges from zero set wrap flag
// R12 - wrap interrupt can wake from idle
// R13 - software strobes clock master at quarter rate
// R14 - two-wire master checks clock really released
// R15 - data falling while clock high sets start flag
// R16 - data line low if msb or port zero
// R17 - after start, hold clock low until flag cleared
// R18 - two-wire slave samples on rising clock
// R19 - after eight bits wrap holds clock low
// R20 - preload fourteen for one acknowledge bit
// R21 - start detector only active in two-wire mode
// R22 - start detector runs without system clock
// R23 - wrap flag set on fifteen to zero
// R24 - clearing start flag releases start hold
// R25 - external clock plus strobe counts toggle writes
// R26 - counter write beats simultaneous increment
//----------------------------------------------------------------
package usu_pkg;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned CNT_W = 4;
   localparam logic [1:0] WIRE_OFF = 2'h0;
   localparam logic [1:0] WIRE_THREE = 2'h1;
   localparam logic [1:0] WIRE_TWO = 2'h2;
   localparam logic [1:0] WIRE_TWO_HOLD = 2'h3;
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
   localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
   localparam logic [CNT_W-1:0] CNT_MAX = 4'hf;
   localparam logic [CNT_W-1:0] CNT_ACK_PRELOAD = 4'he;
   localparam logic [CNT_W-1:0] CNT_TWO = 4'h2;
   localparam logic [2:0] SYNC_RST = 3'h0;
endpackage

// ### usu_spi_master.sv
// behavioural three-wire master standing on the far side of the unit
// assumes a free-running link clock; the serial clock only moves in frames
module usu_spi_master (
   // link side
   input wire logic link_clk_i,
   input wire logic go_i,
   input wire logic [7:0] tx_i,
   input wire logic miso_i,
   // pins and result
   output logic sclk_o,
   output logic mosi_o,
   output logic [7:0] rx_o,
   output logic busy_o
);
   timeunit 1ns;
   timeprecision 100ps;
   //----------------------------------------------------------------
   // frame engine, mode 0, eight link clocks per half period
   //----------------------------------------------------------------
   initial
   begin
      sclk_o = 1'b0;
      mosi_o = 1'b0;
      rx_o = 8'h00;
      busy_o = 1'b0;
   end
   always @(posedge go_i)
   begin : frame
      int i;
      busy_o = 1'b1;
      rx_o = 8'h00;
      for (i = 7; i >= 0; i--)
      begin
         mosi_o = tx_i[i];
         repeat (8) @(posedge link_clk_i);
         sclk_o = 1'b1;
         rx_o = {rx_o[6:0], miso_i};
         repeat (8) @(posedge link_clk_i);
         sclk_o = 1'b0;
      end
      repeat (8) @(posedge link_clk_i);
      // released line: show the inverse so a stale sample is caught
      mosi_o = ~mosi_o;
      busy_o = 1'b0;
   end
endmodule // usu_spi_master
